/* rtl/ifsb_defines.vh */
// Offsets, field positions, masks and reset values of the interrupt flag status bank
`ifndef IFSB_DEFINES_VH
`define IFSB_DEFINES_VH

// Register offsets (word index on the plain register port)
`define IFSB_ADDR_W 4
`define IFSB_OFF_FLAG0 4'h0
`define IFSB_OFF_FLAG1 4'h1
`define IFSB_OFF_MASK0 4'h2
`define IFSB_OFF_MASK1 4'h3
`define IFSB_OFF_PEND0 4'h4
`define IFSB_OFF_PEND1 4'h5

// Implemented bit masks; zero positions are unimplemented
`define IFSB_IMPL0 16'h3fef
`define IFSB_IMPL1 16'hfedf

// Reset values
`define IFSB_FLAG_RST 16'h0000
`define IFSB_MASK_RST 16'h0000

// Flag register 0 fields
`define IFSB_F0_EXT_IRQ0 0
`define IFSB_F0_CAPTURE_CH1 1
`define IFSB_F0_COMPARE_CH1 2
`define IFSB_F0_TIMER1 3
`define IFSB_F0_CAPTURE_CH2 5
`define IFSB_F0_COMPARE_CH2 6
`define IFSB_F0_TIMER2 7
`define IFSB_F0_TIMER3 8
`define IFSB_F0_SPI1_FAULT 9
`define IFSB_F0_SPI1_EVENT 10
`define IFSB_F0_UART1_RECEIVE 11
`define IFSB_F0_UART1_TRANSMIT 12
`define IFSB_F0_ADC1_DONE 13

// Flag register 1 fields
`define IFSB_F1_I2C1_SLAVE 0
`define IFSB_F1_I2C1_MASTER 1
`define IFSB_F1_COMPARATOR 2
`define IFSB_F1_CHANGE_NOTIFY 3
`define IFSB_F1_EXT_IRQ1 4
`define IFSB_F1_CAPTURE_CH7 6
`define IFSB_F1_CAPTURE_CH8 7
`define IFSB_F1_COMPARE_CH3 9
`define IFSB_F1_COMPARE_CH4 10
`define IFSB_F1_TIMER4 11
`define IFSB_F1_TIMER5 12
`define IFSB_F1_EXT_IRQ2 13
`define IFSB_F1_UART2_RECEIVE 14
`define IFSB_F1_UART2_TRANSMIT 15

`endif

/* rtl/ifsb_sync.v */
// Two-flop synchroniser for a vector of asynchronous request pins
`timescale 1ns/1ps
`default_nettype none

module ifsb_sync #(
   parameter WIDTH = 16
) (
   input wire clk, // System clock
   input wire resetn, // Asynchronous reset, active low
   input wire [WIDTH-1:0] din, // Asynchronous inputs
   output reg [WIDTH-1:0] dout // Synchronised outputs
);

   reg [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= {WIDTH{1'b0}};
         dout <= {WIDTH{1'b0}};
      end else begin
         meta_r <= din;
         dout <= meta_r;
      end
   end

endmodule // ifsb_sync

`default_nettype wire

/* rtl/ifsb_flag_reg.v */
// One 16-bit bank of sticky hardware-set, write-one-to-clear flags
`timescale 1ns/1ps
`default_nettype none
`include "ifsb_defines.vh"

module ifsb_flag_reg #(
   parameter [15:0] IMPL = 16'hFFFF
) (
   input wire clk, // System clock
   input wire resetn, // Asynchronous reset, active low
   input wire [15:0] req_rise, // One-cycle request events
   input wire clr_en, // Write strobe aimed at this bank
   input wire [15:0] clr_data, // Ones clear the matching flags
   output reg [15:0] flags_r // Current flags
);

   reg [15:0] flags_nxt;

   // Event set wins over a clear in the same cycle; unimplemented bits stay zero
   always @* begin
      flags_nxt = flags_r;
      if (clr_en)
         flags_nxt = flags_nxt & ~clr_data;
      flags_nxt = (flags_nxt | req_rise) & IMPL; // [RL3] [RL5]
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         flags_r <= `IFSB_FLAG_RST; // [RL4]
      else
         flags_r <= flags_nxt;
   end

endmodule // ifsb_flag_reg

`default_nettype wire

/* rtl/ifsb_top.v */
// Interrupt flag status bank: two flag registers, masks and one interrupt line
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ifsb_defines.vh"

// How it works
// [RL1] Capture channel 1 flag at bank0 bit 1
// [RL2] External irq 0 flag at bank0 bit 0
// [RL3] Request sets flag; stays until software clears
// [RL4] Zero means no request; reset clears all
// [RL5] Unimplemented bits ignore writes, read zero
// [RL6] Bank1 holds listed sources; bits 8,5 unused
module ifsb_top (
   input wire clk, // System clock, 10 MHz
   input wire resetn, // Asynchronous reset, active low
   input wire [3:0] reg_addr, // Register word index
   input wire [15:0] reg_wdata, // Write data
   input wire reg_wr, // Write strobe, one cycle
   input wire reg_rd, // Read strobe, one cycle
   output reg [15:0] reg_rdata, // Read data, valid the cycle after reg_rd
   input wire ext_irq0_req, // External interrupt 0, async pin
   input wire ext_irq1_req, // External interrupt 1, async pin
   input wire ext_irq2_req, // External interrupt 2, async pin
   input wire capture_ch1_req, // Input capture 1 request
   input wire capture_ch2_req, // Input capture 2 request
   input wire capture_ch7_req, // Input capture 7 request
   input wire capture_ch8_req, // Input capture 8 request
   input wire compare_ch1_req, // Output compare 1 request
   input wire compare_ch2_req, // Output compare 2 request
   input wire compare_ch3_req, // Output compare 3 request
   input wire compare_ch4_req, // Output compare 4 request
   input wire timer1_req, // Timer 1 request
   input wire timer2_req, // Timer 2 request
   input wire timer3_req, // Timer 3 request
   input wire timer4_req, // Timer 4 request
   input wire timer5_req, // Timer 5 request
   input wire spi1_fault_req, // SPI1 fault request
   input wire spi1_event_req, // SPI1 event request
   input wire uart1_receive_req, // UART1 receive request
   input wire uart1_transmit_req, // UART1 transmit request
   input wire uart2_receive_req, // UART2 receive request
   input wire uart2_transmit_req, // UART2 transmit request
   input wire adc1_done_req, // Conversion complete request
   input wire change_notify_req, // Change notification request, async
   input wire comparator_req, // Comparator request, async
   input wire i2c1_master_req, // I2C1 master event request
   input wire i2c1_slave_req, // I2C1 slave event request
   output reg irq_r // Interrupt, high while an unmasked flag is set
);

   wire [15:0] flag0;
   wire [15:0] flag1;
   wire [15:0] async_sync;
   reg [15:0] mask0_r;
   reg [15:0] mask1_r;
   reg [15:0] level0_r;
   reg [15:0] level1_r;
   reg [15:0] req0;
   reg [15:0] req1;
   reg [15:0] rdata_nxt;
   wire [15:0] rise0;
   wire [15:0] rise1;
   wire wr_flag0;
   wire wr_flag1;

   // Pins from outside the clock domain go through two flops first
   ifsb_sync #(.WIDTH(16)) u_sync (
      .clk(clk),
      .resetn(resetn),
      .din({11'h000, comparator_req, change_notify_req, ext_irq2_req, ext_irq1_req, ext_irq0_req}),
      .dout(async_sync)
   );

   // Source-to-bit map of bank 0
   always @* begin
      req0 = 16'h0000;
      req0[`IFSB_F0_EXT_IRQ0] = async_sync[0]; // [RL2]
      req0[`IFSB_F0_CAPTURE_CH1] = capture_ch1_req; // [RL1]
      req0[`IFSB_F0_COMPARE_CH1] = compare_ch1_req;
      req0[`IFSB_F0_TIMER1] = timer1_req;
      req0[`IFSB_F0_CAPTURE_CH2] = capture_ch2_req;
      req0[`IFSB_F0_COMPARE_CH2] = compare_ch2_req;
      req0[`IFSB_F0_TIMER2] = timer2_req;
      req0[`IFSB_F0_TIMER3] = timer3_req;
      req0[`IFSB_F0_SPI1_FAULT] = spi1_fault_req;
      req0[`IFSB_F0_SPI1_EVENT] = spi1_event_req;
      req0[`IFSB_F0_UART1_RECEIVE] = uart1_receive_req;
      req0[`IFSB_F0_UART1_TRANSMIT] = uart1_transmit_req;
      req0[`IFSB_F0_ADC1_DONE] = adc1_done_req;
   end

   // Source-to-bit map of bank 1
   always @* begin
      req1 = 16'h0000;
      req1[`IFSB_F1_I2C1_SLAVE] = i2c1_slave_req; // [RL6]
      req1[`IFSB_F1_I2C1_MASTER] = i2c1_master_req; // [RL6]
      req1[`IFSB_F1_COMPARATOR] = async_sync[4]; // [RL6]
      req1[`IFSB_F1_CHANGE_NOTIFY] = async_sync[3]; // [RL6]
      req1[`IFSB_F1_EXT_IRQ1] = async_sync[1]; // [RL6]
      req1[`IFSB_F1_CAPTURE_CH7] = capture_ch7_req; // [RL6]
      req1[`IFSB_F1_CAPTURE_CH8] = capture_ch8_req; // [RL6]
      req1[`IFSB_F1_COMPARE_CH3] = compare_ch3_req; // [RL6]
      req1[`IFSB_F1_COMPARE_CH4] = compare_ch4_req; // [RL6]
      req1[`IFSB_F1_TIMER4] = timer4_req; // [RL6]
      req1[`IFSB_F1_TIMER5] = timer5_req; // [RL6]
      req1[`IFSB_F1_EXT_IRQ2] = async_sync[2]; // [RL6]
      req1[`IFSB_F1_UART2_RECEIVE] = uart2_receive_req; // [RL6]
      req1[`IFSB_F1_UART2_TRANSMIT] = uart2_transmit_req; // [RL6]
   end

   // Previous request levels, so a held request sets its flag only once
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         level0_r <= 16'h0000;
         level1_r <= 16'h0000;
      end else begin
         level0_r <= req0;
         level1_r <= req1;
      end
   end

   // Rising edges are the request events; a level held across a clear does not re-set
   assign rise0 = req0 & ~level0_r; // [RL3]
   assign rise1 = req1 & ~level1_r; // [RL3]

   assign wr_flag0 = reg_wr && (reg_addr == `IFSB_OFF_FLAG0);
   assign wr_flag1 = reg_wr && (reg_addr == `IFSB_OFF_FLAG1);

   // Bank 0 flags
   ifsb_flag_reg #(.IMPL(`IFSB_IMPL0)) u_flag0 (
      .clk(clk),
      .resetn(resetn),
      .req_rise(rise0),
      .clr_en(wr_flag0),
      .clr_data(reg_wdata),
      .flags_r(flag0)
   );

   // Bank 1 flags
   ifsb_flag_reg #(.IMPL(`IFSB_IMPL1)) u_flag1 (
      .clk(clk),
      .resetn(resetn),
      .req_rise(rise1),
      .clr_en(wr_flag1),
      .clr_data(reg_wdata),
      .flags_r(flag1)
   );

   // Mask registers; unimplemented positions cannot be enabled
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mask0_r <= `IFSB_MASK_RST;
         mask1_r <= `IFSB_MASK_RST;
      end else if (reg_wr) begin
         if (reg_addr == `IFSB_OFF_MASK0)
            mask0_r <= reg_wdata & `IFSB_IMPL0; // [RL5]
         if (reg_addr == `IFSB_OFF_MASK1)
            mask1_r <= reg_wdata & `IFSB_IMPL1; // [RL5]
      end
   end

   // Read mux; unmapped addresses read zero
   always @* begin
      case (reg_addr)
         `IFSB_OFF_FLAG0: rdata_nxt = flag0;
         `IFSB_OFF_FLAG1: rdata_nxt = flag1;
         `IFSB_OFF_MASK0: rdata_nxt = mask0_r;
         `IFSB_OFF_MASK1: rdata_nxt = mask1_r;
         `IFSB_OFF_PEND0: rdata_nxt = flag0 & mask0_r;
         `IFSB_OFF_PEND1: rdata_nxt = flag1 & mask1_r;
         default: rdata_nxt = 16'h0000;
      endcase
   end

   // Read data stands one cycle after the strobe only, zero otherwise
   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
         reg_rdata <= rdata_nxt; // [RL4] [RL5]
      else
         reg_rdata <= 16'h0000;
   end

   // Registered interrupt: lags the flags by one cycle, keeps the output glitch free
   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         irq_r <= 1'b0;
      else
         irq_r <= |(flag0 & mask0_r) || |(flag1 & mask1_r);
   end

endmodule // ifsb_top

`default_nettype wire

/* tb/ifsb_top_asserts.sv */
// Port-level checks on the interrupt flag status bank
`timescale 1ns/1ps
`default_nettype none
module ifsb_chk (
   input wire logic clk, // Clock
   input wire logic resetn, // Reset, active low
   input wire logic [3:0] reg_addr, // Word index
   input wire logic reg_rd, // Read strobe
   input wire logic [15:0] reg_rdata, // Read data
   input wire logic ext_irq0_req, // Async pin
   input wire logic capture_ch1_req, // Capture 1
   input wire logic timer5_req, // Timer 5
   input wire logic irq_r // Interrupt line
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Same-clock source lands one cycle after its rise
   property p_cap1;
      $rose(capture_ch1_req) ##1 (reg_rd && reg_addr == 4'h0) |=> reg_rdata[1];
   endproperty
   a_cap1: assert property (p_cap1) else $error("capture 1 flag missing");
   // Pin source pays two extra synchroniser cycles
   property p_ext0;
      $rose(ext_irq0_req) ##3 (reg_rd && reg_addr == 4'h0) |=> reg_rdata[0];
   endproperty
   a_ext0: assert property (p_ext0) else $error("ext irq 0 flag missing");
   // A set flag survives until cleared, so two reads never drop a bit
   property p_sticky;
      (reg_rd && reg_addr == 4'h0) ##1 (reg_rd && reg_addr == 4'h0)
         |=> (reg_rdata & $past(reg_rdata)) == $past(reg_rdata);
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped");
   property p_gap0;
      reg_rd && reg_addr == 4'h0 |=> (reg_rdata & 16'hc010) == 16'h0000;
   endproperty
   a_gap0: assert property (p_gap0) else $error("bank 0 gap bit set");
   property p_gap1;
      reg_rd && reg_addr == 4'h1 |=> (reg_rdata & 16'h0120) == 16'h0000;
   endproperty
   a_gap1: assert property (p_gap1) else $error("bank 1 gap bit set");
   property p_tmr5;
      $rose(timer5_req) ##1 (reg_rd && reg_addr == 4'h1) |=> reg_rdata[12];
   endproperty
   a_tmr5: assert property (p_tmr5) else $error("timer 5 flag missing");
   // Interrupt line follows the same pending view in the same cycle as the read data
   property p_irq;
      (reg_rd && reg_addr == 4'h4) ##1 (reg_rdata != 16'h0000) |-> irq_r;
   endproperty
   a_irq: assert property (p_irq) else $error("irq low with pending flag");
endmodule // ifsb_chk
bind ifsb_top ifsb_chk u_chk (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .ext_irq0_req(ext_irq0_req), .capture_ch1_req(capture_ch1_req),
   .timer5_req(timer5_req), .irq_r(irq_r));
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the interrupt flag status bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam [31:0] IMP = 32'hfedf_3fef; // Implemented flags, bank 1 over bank 0
   localparam [31:0] ASY = 32'h201c_0001; // Pins behind the synchroniser
   logic clk, resetn, reg_wr, reg_rd, irq_r;
   logic rd_d = 1'b0;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [31:0] rq, pat, msk;
   logic [15:0] expq[$];
   integer seed, fails, checked;
   integer cyc = 0;
   ifsb_top u_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_r(irq_r),
      .ext_irq0_req(rq[0]), .capture_ch1_req(rq[1]), .compare_ch1_req(rq[2]), .timer1_req(rq[3]),
      .capture_ch2_req(rq[5]), .compare_ch2_req(rq[6]), .timer2_req(rq[7]), .timer3_req(rq[8]),
      .spi1_fault_req(rq[9]), .spi1_event_req(rq[10]), .uart1_receive_req(rq[11]),
      .uart1_transmit_req(rq[12]), .adc1_done_req(rq[13]), .i2c1_slave_req(rq[16]),
      .i2c1_master_req(rq[17]), .comparator_req(rq[18]), .change_notify_req(rq[19]),
      .ext_irq1_req(rq[20]), .capture_ch7_req(rq[22]), .capture_ch8_req(rq[23]),
      .compare_ch3_req(rq[25]), .compare_ch4_req(rq[26]), .timer4_req(rq[27]), .timer5_req(rq[28]),
      .ext_irq2_req(rq[29]), .uart2_receive_req(rq[30]), .uart2_transmit_req(rq[31]));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   // Gap cycle after each strobe keeps one assignment per signal per edge
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input int n);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      repeat (n) begin
         expq.push_back(e);
         @(posedge clk);
      end
      reg_rd <= 1'b0;
   endtask
   task automatic close_out;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Read data stand only in the cycle after the strobe; pair them with the oldest note
   always @(posedge clk) begin
      rd_d <= reg_rd;
      cyc <= cyc + 1;
      if (rd_d)
         chk("reg_rdata", expq.pop_front(), reg_rdata);
      if (cyc == 4000) begin
         fails++;
         close_out;
      end
   end
   initial begin
      seed = 8;
      fails = 0;
      checked = 0;
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      rq = 32'h0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      wr(4'hf, 16'hffff);
      wr(4'h4, 16'hffff);
      for (int a = 0; a < 16; a++)
         rd(a[3:0], 16'h0000, 1);
      $display("test reset done");
      wr(4'h2, 16'hffff);
      wr(4'h3, 16'hffff);
      rd(4'h2, 16'h3fef, 1);
      rd(4'h3, 16'hfedf, 1);
      // Request held high through the clear must not set the flag again
      for (int k = 0; k < 32; k++) begin
         if (IMP[k]) begin
            @(posedge clk);
            rq <= 32'h1 << k;
            repeat (ASY[k] ? 2 : 0) @(posedge clk);
            rd({3'h0, k[4]}, 16'h1 << k[3:0], 2);
            chk("irq_r", 16'h0001, {15'h0, irq_r});
            wr({3'h0, k[4]}, 16'h1 << k[3:0]);
            rd({3'h0, k[4]}, 16'h0000, 1);
            chk("irq_r", 16'h0000, {15'h0, irq_r});
            @(posedge clk);
            rq <= 32'h0;
         end
      end
      $display("test per source done");
      pat = $random(seed) & IMP;
      msk = $random(seed) & IMP;
      wr(4'h2, msk[15:0]);
      wr(4'h3, msk[31:16]);
      @(posedge clk);
      rq <= pat;
      repeat (4) @(posedge clk);
      rd(4'h0, pat[15:0], 2);
      rd(4'h1, pat[31:16], 2);
      rd(4'h4, pat[15:0] & msk[15:0], 1);
      rd(4'h5, pat[31:16] & msk[31:16], 1);
      chk("irq_r", {15'h0, |(pat & msk)}, {15'h0, irq_r});
      wr(4'h2, 16'h0000);
      wr(4'h3, 16'h0000);
      // The line is registered, so the last mask write shows one edge later
      repeat (2) @(posedge clk);
      chk("irq_r", 16'h0000, {15'h0, irq_r});
      wr(4'h0, 16'hffff);
      wr(4'h1, 16'hffff);
      rd(4'h0, 16'h0000, 1);
      rd(4'h1, 16'h0000, 1);
      $display("test random done");
      close_out;
   end
endmodule // tb_top
`default_nettype wire
